// [rtl/disk_cmd_regs.svh]
/*
  Command codes, status codes, field positions and timing counts of the
  disk command decoder. Assumes a 250 MHz clock.
*/
`ifndef DISK_CMD_REGS_SVH
`define DISK_CMD_REGS_SVH

// ----------------------------------------------------------------
// Opcodes in command byte 0
// ----------------------------------------------------------------
`define OP_TEST_READY 8'h00
`define OP_FMT_BAD 8'h07
`define OP_READ 8'h08
`define OP_VERIFY 8'h09
`define OP_WRITE 8'h0a
`define OP_SEEK 8'h0b
`define OP_INIT 8'h0c

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define ST_OK 8'h00
`define ST_SEEKING 8'h08
`define ST_NOT_INIT 8'h0a
`define ST_BAD_TRACK 8'h19
`define ST_BAD_CMD 8'h20
`define ST_BAD_ADDR 8'h21
`define ST_SEEK_TIMEOUT 8'h22

// ----------------------------------------------------------------
// Command block fields
// ----------------------------------------------------------------
`define CB_LEN 3'd6
`define PB_LEN 3'd7
`define UNIT_HI 6
`define UNIT_LO 5
`define TAPE_UNIT 2'd2
`define RETRY_BIT 7
`define ECC_BIT 6

// ----------------------------------------------------------------
// Parameter block fields
// ----------------------------------------------------------------
`define PB_SERVO_BIT 7
`define PB_HEADS_BYTE 2
`define PB_RATE_BYTE 7
`define HEADS_HS3 4'd8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define SEEK_WAIT_S 2
`define SEEK_WAIT_CYCLES (`SEEK_WAIT_S * 1000000000 / `CLK_PERIOD_NS)
`define SECTORS_PER_TRACK 24'd32
`define STEP_3MS_NS 3000000
`define STEP_200US_NS 200000
`define STEP_70US_NS 70000
`define STEP_30US_NS 30000
`define STEP_15US_NS 15000
`define STEP_12US_NS 12000

`endif

// [rtl/disk_cmd_pkg.sv]
/*
  Types of the disk command decoder: state enumeration and state record.
  Assumes disk_cmd_regs.svh supplies the numeric constants.
*/
package disk_cmd_pkg;

  typedef enum logic [3:0] {
    S_CMD, S_PARM, S_DECODE, S_WAIT_SEEK, S_DIV, S_ISSUE, S_ENGINE, S_STATUS
  } state_t;

  typedef struct packed {
    state_t st;
    logic [5:0][7:0] cbuf;
    logic [2:0] idx;
    logic [1:0][7:0][7:0] params;
    logic [1:0] init;
    logic [1:0] seeking;
    logic [1:0] verify_pend;
    logic [1:0] sk_sync1;
    logic [1:0] sk_sync2;
    logic [1:0] sk_sync3;
    logic [28:0] wait_cnt;
    logic [23:0] rem;
    logic [23:0] quo;
    logic [23:0] dvs;
    logic [4:0] bitn;
    logic pass;
    logic host_ready;
    logic busy;
    logic status_valid;
    logic [7:0] status_code;
    logic op_start;
    logic [7:0] op_kind;
    logic [1:0] op_drive;
    logic [23:0] op_lba;
    logic [8:0] op_count;
    logic op_retry;
    logic op_ecc;
    logic op_bad_flag;
    logic op_no_xfer;
    logic op_buf_clobber;
    logic op_servo_gap;
    logic op_verify_seek;
    logic [15:0] op_cyl;
    logic [3:0] op_head;
    logic seek_start;
    logic rwc_line;
    logic precomp_line;
    logic [19:0] step_cycles;
    logic [3:0] ecc_burst;
  } ctl_t;

endpackage : disk_cmd_pkg

// [rtl/disk_command_decoder.sv]
/*
  Disk command decoder: takes six-byte command blocks from the host,
  checks them, translates logical sector addresses, and hands work to a
  disk engine and seek requests to the drives.
  Assumes host bytes and engine signals share clk; seek_complete comes
  from the drives and is synchronised here.
*/
// Summary of operation
// - Bad-track format writes ID bit 1 flag
// - Flagged track access returns error 19
// - Read: count byte 4, address bytes 1-3
// - Read count zero means 256 sectors
// - Read recovery: byte 5 retry, ECC bits
// - Verify reads without transfer, reports errors
// - Verify may overwrite the disk buffer
// - Write: count byte 4, address bytes 1-3
// - Write count zero means 256 sectors
// - Seek derives cylinder, head from address
// - Seek status returned immediately
// - Seek position checked at next access
// - Seek error status means not issued
// - Overlapped seeks on both drives allowed
// - Busy until seek done, two seconds maximum
// - Ready test during seek returns 08
// - Uninitialised drive access returns 0A
// - Tape needs drive 0 initialised
// - Eight-byte parameter block stored per drive
// - Sizes one-based, cylinder thresholds zero-based
// - Eight or more heads: line is head bit 3
// - Fewer heads: reduced current from threshold
// - Byte 2 servo/heads, byte 7 rate/burst
// - Step rate nibble decode table
// - Servo flag leaves gap when formatting
`include "disk_cmd_regs.svh"

module disk_command_decoder #(
  parameter logic [28:0] SEEK_WAIT_CYCLES = 29'(`SEEK_WAIT_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host byte stream
  input wire logic host_valid,
  input wire logic [7:0] host_byte,
  output logic host_ready,
  output logic busy,
  output logic status_valid,
  output logic [7:0] status_code,
  // Disk engine request
  output logic op_start,
  output logic [7:0] op_kind,
  output logic [1:0] op_drive,
  output logic [23:0] op_lba,
  output logic [8:0] op_count,
  output logic op_retry,
  output logic op_ecc,
  output logic op_bad_flag,
  output logic op_no_xfer,
  output logic op_buf_clobber,
  output logic op_servo_gap,
  output logic op_verify_seek,
  output logic [15:0] op_cyl,
  output logic [3:0] op_head,
  // Disk engine answer
  input wire logic engine_done,
  input wire logic engine_err,
  input wire logic [7:0] engine_err_code,
  input wire logic engine_bad_track,
  // Drive control
  output logic seek_start,
  input wire logic [1:0] seek_complete,
  output logic rwc_line,
  output logic precomp_line,
  output logic [19:0] step_cycles,
  output logic [3:0] ecc_burst
);

  disk_cmd_pkg::ctl_t q;
  disk_cmd_pkg::ctl_t d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One restoring division step: shifts in the next dividend bit
  function automatic logic [47:0] div_step(input logic [23:0] rem, input logic [23:0] quo,
                                           input logic [23:0] dvs);
    logic [24:0] r;
    logic [24:0] t;
    r = {rem, quo[23]};
    t = r - {1'b0, dvs};
    if (!t[24]) begin
      div_step = {t[23:0], quo[22:0], 1'b1};
    end else begin
      div_step = {r[23:0], quo[22:0], 1'b0};
    end
  endfunction : div_step

  // Step period in clock cycles for a rate nibble
  function automatic logic [19:0] step_decode(input logic [3:0] code);
    case (code)
      4'h4: step_decode = 20'(`STEP_200US_NS / `CLK_PERIOD_NS);
      4'h5: step_decode = 20'(`STEP_70US_NS / `CLK_PERIOD_NS);
      4'h6: step_decode = 20'(`STEP_30US_NS / `CLK_PERIOD_NS);
      4'h7: step_decode = 20'(`STEP_15US_NS / `CLK_PERIOD_NS);
      4'h8: step_decode = 20'(`STEP_12US_NS / `CLK_PERIOD_NS);
      default: step_decode = 20'(`STEP_3MS_NS / `CLK_PERIOD_NS);
    endcase
  endfunction : step_decode

  function automatic logic [15:0] word_at(input logic [7:0][7:0] p, input int hi);
    word_at = {p[hi], p[hi+1]};
  endfunction : word_at

  // ----------------------------------------------------------------
  // Decoded command fields
  // ----------------------------------------------------------------
  logic [7:0] opc;
  logic [1:0] unit;
  logic drv;
  logic [23:0] lba;
  logic [7:0][7:0] dp;
  logic [3:0] heads;
  logic [47:0] step_res;
  logic [1:0] sk_rise;

  assign opc = q.cbuf[0];
  assign unit = q.cbuf[1][`UNIT_HI:`UNIT_LO];
  assign drv = unit[0];
  assign lba = {4'h0, q.cbuf[1][3:0], q.cbuf[2], q.cbuf[3]};
  assign dp = q.params[drv];
  assign heads = dp[`PB_HEADS_BYTE][3:0];
  assign step_res = div_step(q.rem, q.quo, q.dvs);
  assign sk_rise = q.sk_sync2 & ~q.sk_sync3;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.status_valid = 1'b0;
    d.op_start = 1'b0;
    d.seek_start = 1'b0;
    d.sk_sync1 = seek_complete;
    d.sk_sync2 = q.sk_sync1;
    d.sk_sync3 = q.sk_sync2;
    for (int i = 0; i < 2; i++) begin
      if (sk_rise[i]) begin
        d.seeking[i] = 1'b0;
      end
    end
    case (q.st)
      disk_cmd_pkg::S_CMD: begin
        if (host_valid && q.host_ready) begin
          d.cbuf[q.idx] = host_byte;
          d.idx = q.idx + 3'd1;
          if (q.idx == `CB_LEN - 3'd1) begin
            d.idx = 3'd0;
            d.host_ready = 1'b0;
            d.busy = 1'b1;
            d.st = disk_cmd_pkg::S_DECODE;
          end
        end
      end
      disk_cmd_pkg::S_PARM: begin
        if (host_valid && q.host_ready) begin
          d.params[drv][q.idx] = host_byte;
          d.idx = q.idx + 3'd1;
          if (q.idx == `PB_LEN) begin
            d.idx = 3'd0;
            d.host_ready = 1'b0;
            d.init[drv] = 1'b1;
            d.status_code = `ST_OK;
            d.st = disk_cmd_pkg::S_STATUS;
          end
        end
      end
      disk_cmd_pkg::S_DECODE: begin
        d.st = disk_cmd_pkg::S_STATUS;
        if (unit == `TAPE_UNIT && opc == `OP_TEST_READY) begin
          d.status_code = q.init[0] ? `ST_OK : `ST_NOT_INIT;
        end else if (unit[1]) begin
          d.status_code = `ST_BAD_CMD;
        end else if (opc == `OP_INIT) begin
          d.host_ready = 1'b1;
          d.st = disk_cmd_pkg::S_PARM;
        end else if (opc != `OP_TEST_READY && opc != `OP_FMT_BAD && opc != `OP_READ &&
                     opc != `OP_VERIFY && opc != `OP_WRITE && opc != `OP_SEEK) begin
          d.status_code = `ST_BAD_CMD;
        end else if (!q.init[drv]) begin
          d.status_code = `ST_NOT_INIT;
        end else if (opc == `OP_TEST_READY) begin
          d.status_code = q.seeking[drv] ? `ST_SEEKING : `ST_OK;
        end else if (q.seeking[drv]) begin
          d.wait_cnt = '0;
          d.st = disk_cmd_pkg::S_WAIT_SEEK;
        end else begin
          d.rem = '0;
          d.quo = lba;
          d.dvs = `SECTORS_PER_TRACK;
          d.bitn = '0;
          d.pass = 1'b0;
          d.st = disk_cmd_pkg::S_DIV;
        end
      end
      disk_cmd_pkg::S_WAIT_SEEK: begin
        d.wait_cnt = q.wait_cnt + 29'd1;
        if (!q.seeking[drv]) begin
          d.rem = '0;
          d.quo = lba;
          d.dvs = `SECTORS_PER_TRACK;
          d.bitn = '0;
          d.pass = 1'b0;
          d.st = disk_cmd_pkg::S_DIV;
        end else if (q.wait_cnt == SEEK_WAIT_CYCLES - 29'd1) begin
          d.status_code = `ST_SEEK_TIMEOUT;
          d.st = disk_cmd_pkg::S_STATUS;
        end
      end
      disk_cmd_pkg::S_DIV: begin
        // Pass 0: track = lba / spt; pass 1: cyl = track / heads, head = rem
        d.rem = step_res[47:24];
        d.quo = step_res[23:0];
        d.bitn = q.bitn + 5'd1;
        if (q.bitn == 5'd23) begin
          d.bitn = '0;
          if (!q.pass) begin
            d.pass = 1'b1;
            d.rem = '0;
            d.dvs = {20'h00000, heads};
          end else begin
            d.op_cyl = step_res[15:0];
            d.op_head = step_res[27:24];
            d.st = disk_cmd_pkg::S_ISSUE;
          end
        end
      end
      disk_cmd_pkg::S_ISSUE: begin
        d.op_drive = unit;
        d.op_lba = lba;
        d.op_kind = opc;
        d.op_count = (q.cbuf[4] == 8'h00) ? 9'h100 : {1'b0, q.cbuf[4]};
        d.op_retry = q.cbuf[5][`RETRY_BIT];
        d.op_ecc = (opc == `OP_READ || opc == `OP_VERIFY) && q.cbuf[5][`ECC_BIT];
        d.op_bad_flag = (opc == `OP_FMT_BAD);
        d.op_no_xfer = (opc == `OP_VERIFY);
        d.op_buf_clobber = (opc == `OP_VERIFY);
        d.op_servo_gap = (opc == `OP_FMT_BAD) && dp[`PB_HEADS_BYTE][`PB_SERVO_BIT];
        d.op_verify_seek = q.verify_pend[drv];
        d.step_cycles = step_decode(dp[`PB_RATE_BYTE][7:4]);
        d.ecc_burst = dp[`PB_RATE_BYTE][3:0];
        // Limits one-based, thresholds zero-based
        if (heads >= `HEADS_HS3) begin
          d.rwc_line = q.op_head[3];
        end else begin
          d.rwc_line = q.op_cyl >= word_at(dp, 3);
        end
        d.precomp_line = q.op_cyl >= {1'b0, dp[5][6:0], dp[6]};
        d.st = disk_cmd_pkg::S_STATUS;
        if (heads == 4'h0 || q.op_cyl >= word_at(dp, 0) || q.quo[23:16] != 8'h00) begin
          d.status_code = `ST_BAD_ADDR;
        end else if (opc == `OP_SEEK) begin
          d.seek_start = 1'b1;
          d.seeking[drv] = 1'b1;
          d.verify_pend[drv] = 1'b1;
          d.status_code = `ST_OK;
        end else begin
          d.op_start = 1'b1;
          if (opc == `OP_READ || opc == `OP_WRITE || opc == `OP_VERIFY) begin
            d.verify_pend[drv] = 1'b0;
          end
          d.st = disk_cmd_pkg::S_ENGINE;
        end
      end
      disk_cmd_pkg::S_ENGINE: begin
        if (engine_done) begin
          if (engine_bad_track) begin
            d.status_code = `ST_BAD_TRACK;
          end else if (engine_err) begin
            d.status_code = engine_err_code;
          end else begin
            d.status_code = `ST_OK;
          end
          d.st = disk_cmd_pkg::S_STATUS;
        end
      end
      disk_cmd_pkg::S_STATUS: begin
        d.status_valid = 1'b1;
        d.busy = 1'b0;
        d.host_ready = 1'b1;
        d.st = disk_cmd_pkg::S_CMD;
      end
      default: begin
        d.st = disk_cmd_pkg::S_CMD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
      q.st <= disk_cmd_pkg::S_CMD;
      q.host_ready <= 1'b1;
      q.step_cycles <= 20'(`STEP_3MS_NS / `CLK_PERIOD_NS);
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_ready = q.host_ready;
  assign busy = q.busy;
  assign status_valid = q.status_valid;
  assign status_code = q.status_code;
  assign op_start = q.op_start;
  assign op_kind = q.op_kind;
  assign op_drive = q.op_drive;
  assign op_lba = q.op_lba;
  assign op_count = q.op_count;
  assign op_retry = q.op_retry;
  assign op_ecc = q.op_ecc;
  assign op_bad_flag = q.op_bad_flag;
  assign op_no_xfer = q.op_no_xfer;
  assign op_buf_clobber = q.op_buf_clobber;
  assign op_servo_gap = q.op_servo_gap;
  assign op_verify_seek = q.op_verify_seek;
  assign op_cyl = q.op_cyl;
  assign op_head = q.op_head;
  assign seek_start = q.seek_start;
  assign rwc_line = q.rwc_line;
  assign precomp_line = q.precomp_line;
  assign step_cycles = q.step_cycles;
  assign ecc_burst = q.ecc_burst;

endmodule : disk_command_decoder

// [verification/disk_command_decoder_props.sv]
/*
  Port checker for disk_command_decoder.
  Bound from the bench top; sees decoder ports only.
*/
module disk_command_decoder_props #(
  parameter logic [28:0] SEEK_WAIT_CYCLES = 29'd400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host side
  input wire logic busy,
  input wire logic status_valid,
  input wire logic [7:0] status_code,
  // Engine side
  input wire logic op_start,
  input wire logic [7:0] op_kind,
  input wire logic [8:0] op_count,
  input wire logic op_ecc,
  input wire logic op_bad_flag,
  input wire logic op_no_xfer,
  input wire logic op_buf_clobber,
  input wire logic seek_start,
  input wire logic engine_done,
  input wire logic engine_err,
  input wire logic [7:0] engine_err_code,
  input wire logic engine_bad_track
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [29:0] busy_cnt_q;
  always_ff @(posedge clk) begin
    if (!rstn || !busy) busy_cnt_q <= 30'h0;
    else busy_cnt_q <= busy_cnt_q + 30'h1;
  end
  // ------
  // Properties
  // ------
  property p_sv_pulse; status_valid |=> !status_valid; endproperty
  a_sv_pulse: assert property (p_sv_pulse)
    else $error("status pulse too long");
  property p_start_pulse; op_start |=> !op_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  property p_seek_ack; seek_start |=> status_valid && status_code == 8'h00; endproperty
  a_seek_ack: assert property (p_seek_ack)
    else $error("seek status late");
  property p_cnt; op_start |-> op_count != 9'h0 && op_count <= 9'h100; endproperty
  a_cnt: assert property (p_cnt)
    else $error("sector count out of range");
  property p_verify; op_start && op_kind == 8'h09 |-> op_no_xfer && op_buf_clobber; endproperty
  a_verify: assert property (p_verify)
    else $error("verify flags wrong");
  property p_bad; op_start |-> op_bad_flag == (op_kind == 8'h07); endproperty
  a_bad: assert property (p_bad)
    else $error("bad track flag wrong");
  property p_ecc_wr; op_start && op_kind == 8'h0a |-> !op_ecc; endproperty
  a_ecc_wr: assert property (p_ecc_wr)
    else $error("ecc on write");
  property p_eng_err;
    engine_done && engine_err |-> ##2 status_valid && status_code == $past(engine_err_code, 2);
  endproperty
  a_eng_err: assert property (p_eng_err)
    else $error("engine error not reported");
  property p_bad_trk;
    engine_done && engine_bad_track |-> ##2 status_valid && status_code == 8'h19;
  endproperty
  a_bad_trk: assert property (p_bad_trk)
    else $error("bad track status missing");
  property p_busy_bound; busy_cnt_q < {1'b0, SEEK_WAIT_CYCLES} + 30'h12c; endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy too long");
  c_seek: cover property (seek_start);
  c_read: cover property (op_start && op_kind == 8'h08);
  c_seeking: cover property (status_valid && status_code == 8'h08);
  c_tmo: cover property (status_valid && status_code == 8'h22);
endmodule : disk_command_decoder_props

// [verification/disk_side_model.sv]
/*
  Disk engine and two drives facing the decoder.
  Shares clk and rstn; bench steers errors and stalls.
*/
module disk_side_model (
  // Clock, reset, control
  input wire logic clk,
  input wire logic rstn,
  input wire logic bad_mode,
  input wire logic stall,
  // Requests
  input wire logic op_start,
  input wire logic seek_start,
  input wire logic [1:0] op_drive,
  // Answers
  output logic engine_done,
  output logic engine_err,
  output logic [7:0] engine_err_code,
  output logic engine_bad_track,
  output logic [1:0] seek_complete
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;
  logic busy_q;
  logic slow_q;
  logic [7:0] sk_q [2];
  always @(posedge clk) begin
    engine_done <= 1'b0;
    if (!rstn) begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      seek_complete <= 2'b11;
      engine_err <= 1'b0;
      engine_bad_track <= 1'b0;
      engine_err_code <= 8'h5a;
    end else begin
      if (op_start) begin
        busy_q <= 1'b1;
        cnt_q <= slow_q ? 5'h14 : 5'h0;
        slow_q <= !slow_q;
      end else if (busy_q && cnt_q == 5'h0) begin
        busy_q <= 1'b0;
        engine_done <= 1'b1;
        engine_err <= bad_mode;
        engine_bad_track <= bad_mode;
        engine_err_code <= bad_mode ? 8'h19 : 8'h00;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 5'h1;
      end else begin
        // Idle answer lines never keep stale values
        engine_err <= !engine_err;
        engine_bad_track <= !engine_bad_track;
        engine_err_code <= ~engine_err_code;
      end
      for (int d = 0; d < 2; d++) begin
        if (seek_start && op_drive == 2'(d)) begin
          seek_complete[d] <= 1'b0;
          sk_q[d] <= 8'h96;
        end else if (!seek_complete[d] && !stall) begin
          if (sk_q[d] == 8'h0) seek_complete[d] <= 1'b1;
          else sk_q[d] <= sk_q[d] - 8'h1;
        end
      end
    end
  end
endmodule : disk_side_model

// [verification/disk_command_decoder_tb.sv]
/*
  Self-checking bench for disk_command_decoder.
  Drives host bytes; disk_side_model answers engine and seeks.
*/
module disk_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] kind;
    logic [1:0] drv;
    logic [19:0] lba;
    logic [8:0] cnt;
    logic [6:0] flg;
    logic [15:0] cyl;
    logic [3:0] hd;
    logic rwc;
    logic pc;
    logic [19:0] step;
    logic [3:0] bur;
  } op_t;
  logic clk, rstn, host_valid, host_ready, busy, status_valid, op_start, seek_start;
  logic [7:0] host_byte, status_code, op_kind, engine_err_code;
  logic [1:0] op_drive, seek_complete;
  logic [23:0] op_lba;
  logic [8:0] op_count;
  logic op_retry, op_ecc, op_bad_flag, op_no_xfer, op_buf_clobber, op_servo_gap;
  logic op_verify_seek, engine_done, engine_err, engine_bad_track, rwc_line, precomp_line;
  logic [15:0] op_cyl;
  logic [3:0] op_head, ecc_burst;
  logic [19:0] step_cycles;
  logic bad_mode, stall;
  int n_fail, tests_run, mc[2], hh[2], rw[2], pr[2], st[2], bu[2], sv[2];
  logic [7:0] sq[$];
  op_t oq[$];
  logic [19:0] kq[$];
  op_t o;
  logic [19:0] a;
  logic [7:0] b;
  logic [7:0] kt[6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h08, 8'h0a};
  logic [7:0] ct[6] = '{8'h05, 8'h00, 8'hff, 8'h00, 8'h01, 8'h80};
  disk_command_decoder #(.SEEK_WAIT_CYCLES(29'd400)) i_disk_command_decoder (.clk, .rstn,
    .host_valid, .host_byte, .host_ready, .busy, .status_valid, .status_code, .op_start,
    .op_kind, .op_drive, .op_lba, .op_count, .op_retry, .op_ecc, .op_bad_flag, .op_no_xfer,
    .op_buf_clobber, .op_servo_gap, .op_verify_seek, .op_cyl, .op_head, .engine_done,
    .engine_err, .engine_err_code, .engine_bad_track, .seek_start, .seek_complete,
    .rwc_line, .precomp_line, .step_cycles, .ecc_burst);
  disk_side_model i_disk_side_model (.clk, .rstn, .bad_mode, .stall, .op_start,
    .seek_start, .op_drive, .engine_done, .engine_err, .engine_err_code,
    .engine_bad_track, .seek_complete);
  always #2 clk = ~clk;
  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [91:0] e, input logic [91:0] g);
    tests_run++;
    if (e !== g) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    while (host_ready !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 9000) n_fail++;
    host_valid = 1'b1;
    host_byte = b;
    @(negedge clk);
    host_valid = 1'b0;
    host_byte = ~b;
  endtask : put
  task automatic cmd(input logic [7:0] k, input logic [1:0] u, input logic [19:0] ad,
                     input logic [7:0] c, input logic [7:0] b5, input logic [7:0] s);
    sq.push_back(s);
    put(k);
    put({1'b0, u, 1'b0, ad[19:16]});
    put(ad[15:8]);
    put(ad[7:0]);
    put(c);
    put(b5);
  endtask : cmd
  task automatic init_drv(input logic [1:0] u, input logic [7:0] p[8]);
    cmd(8'h0c, u, 20'h0, 8'h00, 8'h00, 8'h00);
    foreach (p[i]) put(p[i]);
    mc[u] = {p[0], p[1]};
    hh[u] = p[2][3:0];
    sv[u] = p[2][7];
    rw[u] = {p[3], p[4]};
    pr[u] = {p[5][6:0], p[6]};
    bu[u] = p[7][3:0];
    case (p[7][7:4])
      4'h4: st[u] = 50000;
      4'h5: st[u] = 17500;
      4'h6: st[u] = 7500;
      4'h7: st[u] = 3750;
      4'h8: st[u] = 3000;
      default: st[u] = 750000;
    endcase
  endtask : init_drv
  function automatic op_t mk(logic [7:0] k, logic [1:0] u, logic [19:0] ad, logic [7:0] c,
                             logic [7:0] b5, logic vs);
    op_t r;
    int t;
    t = ad / 32;
    r = {k, u, ad, (c == 8'h0) ? 9'h100 : {1'b0, c}, 7'h0, 16'(t / hh[u]), 4'(t % hh[u]),
         2'h0, 20'(st[u]), 4'(bu[u])};
    r.flg = {b5[7], b5[6] && (k == 8'h08 || k == 8'h09), k == 8'h07, k == 8'h09, k == 8'h09,
             k == 8'h07 && sv[u] == 1, vs};
    r.rwc = hh[u] >= 8 ? r.hd[3] : r.cyl >= rw[u];
    r.pc = r.cyl >= pr[u];
    return r;
  endfunction : mk
  function automatic logic [19:0] ra(logic [1:0] u);
    return 20'($urandom % (mc[u] * hh[u] * 32));
  endfunction : ra
  task automatic drain;
    int n;
    n = 0;
    while (sq.size() + oq.size() + kq.size() > 0 && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask : drain
  // ------
  // Result watcher
  // ------
  always @(negedge clk) begin
    if (rstn === 1'b1 && status_valid === 1'b1)
      chk("status", sq.size() ? 92'(sq.pop_front()) : 'x, 92'(status_code));
    if (rstn === 1'b1 && op_start === 1'b1)
      chk("op", oq.size() ? oq.pop_front() : 'x, {op_kind, op_drive, op_lba[19:0], op_count,
          op_retry, op_ecc, op_bad_flag, op_no_xfer, op_buf_clobber, op_servo_gap,
          op_verify_seek, op_cyl, op_head, rwc_line, precomp_line, step_cycles,
          ecc_burst});
    if (rstn === 1'b1 && seek_start === 1'b1)
      chk("seek", kq.size() ? 92'(kq.pop_front()) : 'x, 92'({op_cyl, op_head}));
  end
  initial begin
    #160000;
    n_fail++;
    close_out();
  end
  // ------
  // Main sequence
  // ------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    host_valid = 1'b0;
    host_byte = 8'h00;
    bad_mode = 1'b0;
    stall = 1'b0;
    void'($urandom(32'h9e987bb9));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    cmd(8'h08, 2'h0, 20'h0, 8'h01, 8'h00, 8'h0a);
    cmd(8'h0a, 2'h1, 20'h0, 8'h01, 8'h00, 8'h0a);
    cmd(8'h05, 2'h0, 20'h0, 8'h01, 8'h00, 8'h20);
    init_drv(2'h0, '{8'h01, 8'h32, 8'h86, 8'h00, 8'hc8, 8'h00, 8'h64, 8'h42});
    init_drv(2'h1, '{8'h01, 8'h00, 8'h08, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80});
    foreach (kt[i]) begin
      a = ra(2'(i % 2));
      b = {2'($urandom), 6'h0};
      o = mk(kt[i], 2'(i % 2), a, ct[i], b, 1'b0);
      oq.push_back(o);
      cmd(kt[i], o.drv, a, ct[i], b, 8'h00);
    end
    drain();
    bad_mode = 1'b1;
    a = ra(2'h0);
    oq.push_back(mk(8'h08, 2'h0, a, 8'h02, 8'h00, 1'b0));
    cmd(8'h08, 2'h0, a, 8'h02, 8'h00, 8'h19);
    drain();
    bad_mode = 1'b0;
    a = ra(2'h0);
    o = mk(8'h0b, 2'h0, a, 8'h00, 8'h00, 1'b0);
    kq.push_back({o.cyl, o.hd});
    cmd(8'h0b, 2'h0, a, 8'h00, 8'h00, 8'h00);
    cmd(8'h00, 2'h0, 20'h0, 8'h00, 8'h00, 8'h08);
    a = ra(2'h1);
    o = mk(8'h0b, 2'h1, a, 8'h00, 8'h00, 1'b0);
    kq.push_back({o.cyl, o.hd});
    cmd(8'h0b, 2'h1, a, 8'h00, 8'h00, 8'h00);
    a = ra(2'h0);
    oq.push_back(mk(8'h08, 2'h0, a, 8'h03, 8'h80, 1'b1));
    cmd(8'h08, 2'h0, a, 8'h03, 8'h80, 8'h00);
    drain();
    stall = 1'b1;
    o = mk(8'h0b, 2'h0, 20'h0, 8'h00, 8'h00, 1'b0);
    kq.push_back({o.cyl, o.hd});
    cmd(8'h0b, 2'h0, 20'h0, 8'h00, 8'h00, 8'h00);
    cmd(8'h08, 2'h0, 20'h0, 8'h01, 8'h00, 8'h22);
    drain();
    stall = 1'b0;
    if (sq.size() + oq.size() + kq.size() > 0) n_fail++;
    close_out();
  end
endmodule : disk_command_decoder_tb

bind disk_command_decoder disk_command_decoder_props #(.SEEK_WAIT_CYCLES(SEEK_WAIT_CYCLES))
  i_props (.clk(clk), .rstn(rstn), .busy(busy), .status_valid(status_valid),
  .status_code(status_code), .op_start(op_start), .op_kind(op_kind), .op_count(op_count),
  .op_ecc(op_ecc), .op_bad_flag(op_bad_flag), .op_no_xfer(op_no_xfer),
  .op_buf_clobber(op_buf_clobber), .seek_start(seek_start), .engine_done(engine_done),
  .engine_err(engine_err), .engine_err_code(engine_err_code),
  .engine_bad_track(engine_bad_track));
